// ==== rtl/epio_pkg.sv ====
// Package: register map, port bit positions and reset values for the emulated ports
package epio_pkg;
  // ---------------------------------------------------------------
  // Register addresses (I/O space)
  // ---------------------------------------------------------------
  localparam logic [31:0] EPIO_ADDR_PORT_C = 32'h0000_0844;
  localparam logic [31:0] EPIO_ADDR_PORT_B = 32'h0000_0845;
  localparam logic [31:0] EPIO_ADDR_PORT_A = 32'h0000_0846;
  localparam logic [31:0] EPIO_ADDR_CTRL = 32'h0000_0847;
  // ---------------------------------------------------------------
  // Bit positions
  // ---------------------------------------------------------------
  localparam int EPIO_POS_BOARD_FAIL = 6;
  localparam int EPIO_POS_ABORT = 7;
  localparam int EPIO_POS_TYPE0 = 2;
  localparam int EPIO_POS_TYPE1 = 3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic EPIO_RST_BOARD_FAIL = 1'b0;
  localparam logic [7:0] EPIO_RST_CTRL = 8'h00;
  localparam logic [2:0] EPIO_RST_SYNC = 3'h7;
  localparam logic EPIO_RST_STABLE = 1'b1;
  localparam logic [7:0] EPIO_RST_RDATA = 8'h00;
  // ---------------------------------------------------------------
  // Register select
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EPIO_SEL_NONE = 3'b000,
    EPIO_SEL_C = 3'b001,
    EPIO_SEL_B = 3'b010,
    EPIO_SEL_A = 3'b011,
    EPIO_SEL_CTRL = 3'b100
  } epio_sel_t;
endpackage : epio_pkg

// ==== rtl/epio_sync_if.sv ====
// Interface: pin synchroniser bundle between top and synchroniser
`timescale 1ns/100ps
interface epio_sync_if;
  logic [2:0] pins_raw;
  logic [2:0] pins_stable;
  modport owner (output pins_raw, input pins_stable);
  modport sync (input pins_raw, output pins_stable);
endinterface : epio_sync_if

// ==== rtl/epio_pin_sync.sv ====
// Three-stage synchroniser with agreement filter for the input pins
`timescale 1ns/100ps
module epio_pin_sync
  import epio_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  epio_sync_if.sync sif
);
  // ---------------------------------------------------------------
  // Synchroniser chain per pin
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      logic [2:0] stage_r;
      logic [2:0] stage_nxt;
      logic stable_r;
      logic stable_nxt;
      // Shift and accept a change once stages two and three agree
      always_comb begin
        stage_nxt = {stage_r[1:0], sif.pins_raw[gi]};
        stable_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : stable_r;
      end
      // Register stage
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          stage_r <= EPIO_RST_SYNC;
          stable_r <= EPIO_RST_STABLE;
        end else begin
          stage_r <= stage_nxt;
          stable_r <= stable_nxt;
        end
      end
      assign sif.pins_stable[gi] = stable_r;
    end
  endgenerate
endmodule : epio_pin_sync

// ==== rtl/epio_ports.sv ====
// Emulated parallel I/O ports: register decode, fixed-direction port bits
`timescale 1ns/100ps
module epio_ports
  import epio_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [31:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  input wire logic abort_n,
  input wire logic module_type_bit0,
  input wire logic module_type_bit1,
  output logic board_fail_out
);
  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  epio_sync_if sif ();
  assign sif.pins_raw = {module_type_bit1, module_type_bit0, abort_n};
  epio_pin_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .sif(sif.sync)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  epio_sel_t sel;
  // Map the four addresses; anything else is not ours
  always_comb begin
    case (io_addr)
      EPIO_ADDR_PORT_C: sel = EPIO_SEL_C;
      EPIO_ADDR_PORT_B: sel = EPIO_SEL_B;
      EPIO_ADDR_PORT_A: sel = EPIO_SEL_A;
      EPIO_ADDR_CTRL: sel = EPIO_SEL_CTRL;
      default: sel = EPIO_SEL_NONE;
    endcase
  end
  assign io_hit = (sel != EPIO_SEL_NONE);

  // ---------------------------------------------------------------
  // Writable state
  // ---------------------------------------------------------------
  logic fail_r;
  logic fail_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  // Only port A bit 6 and the control byte take writes
  always_comb begin
    fail_nxt = fail_r;
    ctrl_nxt = ctrl_r;
    if (io_wr && sel == EPIO_SEL_A) begin
      fail_nxt = io_wdata[EPIO_POS_BOARD_FAIL];
    end
    if (io_wr && sel == EPIO_SEL_CTRL) begin
      ctrl_nxt = io_wdata;
    end
  end
  // Register stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fail_r <= EPIO_RST_BOARD_FAIL;
      ctrl_r <= EPIO_RST_CTRL;
    end else begin
      fail_r <= fail_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end
  assign board_fail_out = fail_r;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // Input bits reflect pins only; control holds no direction bits
  always_comb begin
    rdata_nxt = rdata_r;
    if (io_rd) begin
      rdata_nxt = 8'h00;
      case (sel)
        EPIO_SEL_A: rdata_nxt[EPIO_POS_BOARD_FAIL] = fail_r;
        EPIO_SEL_B: rdata_nxt[EPIO_POS_ABORT] = sif.pins_stable[0];
        EPIO_SEL_C: begin
          rdata_nxt[EPIO_POS_TYPE0] = sif.pins_stable[1];
          rdata_nxt[EPIO_POS_TYPE1] = sif.pins_stable[2];
        end
        EPIO_SEL_CTRL: rdata_nxt = ctrl_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end
  // Register stage; read data change only when a read is presented
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r <= EPIO_RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign io_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Checks: writes
  // ---------------------------------------------------------------
  // A port A write sets the lamp from bit 6
  property p_fail_write;
    @(posedge mclk) disable iff (!rst_n)
      (io_wr && io_addr == EPIO_ADDR_PORT_A) |=>
        (board_fail_out == $past(io_wdata[EPIO_POS_BOARD_FAIL]));
  endproperty
  a_fail_write: assert property (p_fail_write) else $error("board fail not written");
  // Lamp holds between port A writes
  property p_fail_hold;
    @(posedge mclk) disable iff (!rst_n)
      !(io_wr && io_addr == EPIO_ADDR_PORT_A) |=> $stable(board_fail_out);
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("board fail changed");

  // ---------------------------------------------------------------
  // Checks: reads and decode
  // ---------------------------------------------------------------
  // Port B shows the filtered abort pin in bit 7
  property p_read_b;
    @(posedge mclk) disable iff (!rst_n)
      (io_rd && io_addr == EPIO_ADDR_PORT_B) |=>
        (io_rdata == {$past(sif.pins_stable[0]), 7'h00});
  endproperty
  a_read_b: assert property (p_read_b) else $error("port b read wrong");
  // Port C shows the module type code in bits 3 and 2
  property p_read_c;
    @(posedge mclk) disable iff (!rst_n)
      (io_rd && io_addr == EPIO_ADDR_PORT_C) |=>
        (io_rdata == {4'h0, $past(sif.pins_stable[2]), $past(sif.pins_stable[1]), 2'h0});
  endproperty
  a_read_c: assert property (p_read_c) else $error("port c read wrong");
  // Hit exactly on the four decoded addresses
  property p_decode;
    @(posedge mclk) disable iff (!rst_n)
      io_hit == (io_addr >= EPIO_ADDR_PORT_C && io_addr <= EPIO_ADDR_CTRL);
  endproperty
  a_decode: assert property (p_decode) else $error("decode wrong");

  // ---------------------------------------------------------------
  // Checks: control byte
  // ---------------------------------------------------------------
  // Control write, one idle cycle, then read returns the byte
  property p_ctrl_rb;
    @(posedge mclk) disable iff (!rst_n)
      (io_wr && io_addr == EPIO_ADDR_CTRL) ##1 !io_wr ##1
        (io_rd && io_addr == EPIO_ADDR_CTRL && !io_wr) |=> (io_rdata == $past(io_wdata, 3));
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  // Control writes never move a port bit
  property p_ctrl_no_fail;
    @(posedge mclk) disable iff (!rst_n)
      (io_wr && io_addr == EPIO_ADDR_CTRL) |=> $stable(board_fail_out);
  endproperty
  a_ctrl_no_fail: assert property (p_ctrl_no_fail) else $error("control moved port");
  // Reads outside the map return zero
  property p_unmapped;
    @(posedge mclk) disable iff (!rst_n)
      (io_rd && !io_hit) |=> (io_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

  // ---------------------------------------------------------------
  // Checks: isolation and reset
  // ---------------------------------------------------------------
  // Port A reads show the lamp bit only
  property p_read_a;
    @(posedge mclk) disable iff (!rst_n)
      (io_rd && io_addr == EPIO_ADDR_PORT_A) |=>
        (io_rdata == {1'b0, $past(board_fail_out), 6'h00});
  endproperty
  a_read_a: assert property (p_read_a) else $error("port a read wrong");
  // Read data stand until the next read
  property p_rdata_hold;
    @(posedge mclk) disable iff (!rst_n)
      !io_rd |=> $stable(io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");
  // Writes outside the four addresses leave the lamp alone
  property p_unmapped_wr;
    @(posedge mclk) disable iff (!rst_n)
      (io_wr && !io_hit) |=> $stable(board_fail_out);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write used");
  // Writes to the input ports change no output
  property p_input_wr;
    @(posedge mclk) disable iff (!rst_n)
      (io_wr && (io_addr == EPIO_ADDR_PORT_B || io_addr == EPIO_ADDR_PORT_C))
        |=> $stable(board_fail_out);
  endproperty
  a_input_wr: assert property (p_input_wr) else $error("input port write used");
  // A read alone never acts on port state
  property p_read_quiet;
    @(posedge mclk) disable iff (!rst_n)
      (io_rd && !io_wr) |=> $stable(board_fail_out);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read changed the lamp");
  // Control byte changes only on its own write
  property p_ctrl_hold;
    @(posedge mclk) disable iff (!rst_n)
      !(io_wr && io_addr == EPIO_ADDR_CTRL) |=> $stable(ctrl_r);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed");
  // Reset clears the lamp and the read data
  property p_reset_values;
    @(posedge mclk)
      !rst_n |=> (board_fail_out == EPIO_RST_BOARD_FAIL && io_rdata == EPIO_RST_RDATA);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
endmodule : epio_ports

// ==== verification/epio_tb.sv ====
// Testbench: register access checks for the emulated parallel ports
`timescale 1ns/100ps
module testbench
  import epio_pkg::*;
;
  logic mclk;
  logic rst_n;
  logic io_rd;
  logic io_wr;
  logic abort_n;
  logic module_type_bit0;
  logic module_type_bit1;
  logic [31:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_hit;
  logic board_fail_out;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  epio_ports epio_ports_i (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
    .abort_n(abort_n), .module_type_bit0(module_type_bit0),
    .module_type_bit1(module_type_bit1), .board_fail_out(board_fail_out));

  // ---------------------------------------------------------------
  // Clock, timeout and closing report
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Compare and access tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write strobe, lowered a full cycle before any next access
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge mclk);
    #1;
    io_wr = 1'b0;
  endtask

  // One read strobe; decode hit checked while the address stands
  task automatic rd(input logic [31:0] a, input logic [7:0] exp, input logic hit);
    @(posedge mclk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    #1;
    check("io_hit", {7'h00, hit}, {7'h00, io_hit});
    @(posedge mclk);
    #1;
    io_rd = 1'b0;
    check("io_rdata", exp, io_rdata);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    io_addr = 32'h0000_0000;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
    abort_n = 1'b1;
    module_type_bit0 = 1'b0;
    module_type_bit1 = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    check("board_fail_out", 8'h00, {7'h00, board_fail_out});
    rd(EPIO_ADDR_CTRL, EPIO_RST_CTRL, 1'b1);
    wr(EPIO_ADDR_PORT_A, 8'h40);
    check("board_fail_out", 8'h01, {7'h00, board_fail_out});
    rd(EPIO_ADDR_PORT_A, 8'h40, 1'b1);
    wr(EPIO_ADDR_PORT_A, 8'hbf);
    check("board_fail_out", 8'h00, {7'h00, board_fail_out});
    rd(EPIO_ADDR_PORT_A, 8'h00, 1'b1);
    // Control byte is storage only, directions stay fixed
    wr(EPIO_ADDR_CTRL, 8'hff);
    rd(EPIO_ADDR_CTRL, 8'hff, 1'b1);
    wr(EPIO_ADDR_PORT_B, 8'h00);
    rd(EPIO_ADDR_PORT_B, 8'h80, 1'b1);
    abort_n = 1'b0;
    repeat (8) @(posedge mclk);
    rd(EPIO_ADDR_PORT_B, 8'h00, 1'b1);
    check("board_fail_out", 8'h00, {7'h00, board_fail_out});
    // Every module type code
    for (int i = 0; i < 4; i++) begin
      {module_type_bit1, module_type_bit0} = i[1:0];
      repeat (8) @(posedge mclk);
      rd(EPIO_ADDR_PORT_C, {4'h0, i[1:0], 2'b00}, 1'b1);
    end
    wr(EPIO_ADDR_PORT_C, 8'h00);
    rd(EPIO_ADDR_PORT_C, 8'h0c, 1'b1);
    // Neighbouring and aliased addresses are not decoded
    wr(EPIO_ADDR_PORT_A, 8'h40);
    wr(32'h0000_0843, 8'h00);
    wr(32'h0000_1846, 8'h00);
    check("board_fail_out", 8'h01, {7'h00, board_fail_out});
    rd(32'h0000_0848, 8'h00, 1'b0);
    rd(32'h0000_0843, 8'h00, 1'b0);
    // Mid-run reset returns lamp and control byte to reset values
    @(posedge mclk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    check("board_fail_out", {7'h00, EPIO_RST_BOARD_FAIL}, {7'h00, board_fail_out});
    rd(EPIO_ADDR_CTRL, EPIO_RST_CTRL, 1'b1);
    give_verdict();
  end
endmodule // testbench
